// ==== rtl/smart_card_mode_reg_pkg.sv ====
package scm_pkg;

    // register offsets on the plain port
    localparam logic [1:0] OFS_SERIAL_MODE  = 2'h0;
    localparam logic [1:0] OFS_SMART_CARD   = 2'h1;
    localparam logic [1:0] OFS_STATUS       = 2'h2;

    // serial_mode_register fields, smart-card layout
    localparam int BIT_EARLY_END    = 7;
    localparam int BIT_BLOCK_XFER   = 6;
    localparam int BIT_PARITY_EN    = 5;
    localparam int BIT_PARITY_ODD   = 4;
    localparam int BIT_CPB_HI       = 3;
    localparam int BIT_CPB_LO       = 2;
    localparam int BIT_PRESC_HI     = 1;
    localparam int BIT_PRESC_LO     = 0;

    // serial_mode_register fields, normal layout
    localparam int BIT_SYNC_MODE    = 7;
    localparam int BIT_CHAR_7BIT    = 6;
    localparam int BIT_TWO_STOP     = 3;
    localparam int BIT_MULTIPROC    = 2;

    // smart_card_mode_reg and status fields
    localparam int BIT_SMART_SELECT = 0;
    localparam int BIT_TX_END       = 0;
    localparam int BIT_PARITY_ERR   = 1;

    // reset values
    localparam logic [7:0] RST_SERIAL_MODE = 8'h00;
    localparam logic       RST_SMART_SEL   = 1'b0;
    localparam logic       RST_TX_END      = 1'b1;

    // basic clock periods per bit interval
    localparam logic [8:0] CPB_00 = 9'h020;
    localparam logic [8:0] CPB_01 = 9'h040;
    localparam logic [8:0] CPB_10 = 9'h174;
    localparam logic [8:0] CPB_11 = 9'h100;

    // prescaler divide ratios, log2 steps of 2
    localparam logic [6:0] PRESC_DIV_0 = 7'h01;
    localparam logic [6:0] PRESC_DIV_1 = 7'h04;
    localparam logic [6:0] PRESC_DIV_2 = 7'h10;
    localparam logic [6:0] PRESC_DIV_3 = 7'h40;

    // transmit-end advance in whole elementary time units
    localparam logic [4:0] EARLY_END_ETU = 5'h0B;

    typedef struct packed {
        logic       smart_card;
        logic       sync_mode;
        logic       char_7bit;
        logic       two_stop;
        logic       multiproc;
        logic       early_end;
        logic       clock_out_ctrl;
        logic       block_mode;
        logic       parity_en;
        logic       parity_odd;
        logic [8:0] clocks_per_bit;
        logic [1:0] prescaler;
    } scm_cfg_t;

endpackage

// ==== rtl/smart_card_mode_reg_prescaler.sv ====
`timescale 1ns/1ns
module scm_prescaler
    import scm_pkg::*;
(
    input  wire logic       clk,      // system clock
    input  wire logic       reset,    // sync reset, high
    input  wire logic       restart,  // realign divider
    input  wire logic [1:0] select,   // divide select n
    output logic            tick      // one-cycle divided tick
);

    logic [6:0] count;
    logic [6:0] divide;

    always_comb begin
        unique case (select)
            2'b00: divide = PRESC_DIV_0;
            2'b01: divide = PRESC_DIV_1;
            2'b10: divide = PRESC_DIV_2;
            2'b11: divide = PRESC_DIV_3;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset || restart) begin
            count <= 7'h00;
            tick  <= 1'b0;
        end else if (count >= divide - 7'h01) begin
            count <= 7'h00;
            tick  <= 1'b1;
        end else begin
            count <= count + 7'h01;
            tick  <= 1'b0;
        end
    end

endmodule

// ==== rtl/smart_card_mode_reg_top.sv ====
// Behaviour
// R1 - smart-card select picks smart-card field layout
// R2 - early-end sets transmit end 11 etu sooner
// R3 - early-end also enables clock-output control
// R4 - bit 6 selects block or character transfer
// R5 - parity enable adds and checks parity
// R6 - software keeps parity enabled in smart-card mode
// R7 - parity sense: 0 even, 1 odd
// R8 - bits 3:2 give 32/64/372/256 clocks per bit
// R9 - bits 1:0 divide clock by 1/4/16/64
// R10 - normal layout: bit 7 async or synchronous
// R11 - software changes mode only while idle
`timescale 1ns/1ns
module scm_top
    import scm_pkg::*;
#(
    parameter logic [4:0] NORMAL_END_ETU = 5'h0C  // usual end delay in etu
)
(
    input  wire logic       CLK_SYS,        // 250 MHz system clock
    input  wire logic       RESET,          // sync reset, high
    input  wire logic [1:0] ADDR,           // register address
    input  wire logic [7:0] WDATA,          // write data
    input  wire logic       WR,             // write strobe
    input  wire logic       RD,             // read strobe
    output logic      [7:0] RDATA,          // read data, cycle after RD
    input  wire logic       TX_START,       // character transmit start pulse
    input  wire logic [7:0] TX_CHAR,        // character being sent
    input  wire logic       RX_VALID,       // received character pulse
    input  wire logic [7:0] RX_CHAR,        // received character
    input  wire logic       RX_PARITY_BIT,  // received parity bit
    output scm_cfg_t        MODE_CFG,       // decoded mode
    output logic            TX_PARITY_BIT,  // parity bit for TX_CHAR
    output logic            BAUD_TICK,      // prescaled clock tick
    output logic            ETU_TICK,       // one per bit interval
    output logic            TX_END,         // transmit end flag
    output logic            PARITY_ERROR    // sticky parity error
);

    logic [7:0] serial_mode_register;
    logic       smart_card_select;
    logic       parity_error;
    logic       transmit_end_flag;
    logic       presc_tick;
    logic [8:0] clock_count;
    logic       etu_pulse;
    logic [4:0] etu_count;
    logic       timing_active;
    logic [4:0] end_etu;
    logic [8:0] next_clocks_per_bit;
    logic       rx_bad;
    logic       clear_parity;
    scm_cfg_t   next_cfg;

    // software registers
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            serial_mode_register <= RST_SERIAL_MODE;
            smart_card_select    <= RST_SMART_SEL;
        end else if (WR) begin
            if (ADDR == OFS_SERIAL_MODE) begin
                serial_mode_register <= WDATA;
            end
            if (ADDR == OFS_SMART_CARD) begin
                smart_card_select <= WDATA[BIT_SMART_SELECT];
            end
        end
    end

    // read path, unmapped reads zero
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            RDATA <= 8'h00;
        end else if (RD) begin
            unique case (ADDR)
                OFS_SERIAL_MODE: RDATA <= serial_mode_register;
                OFS_SMART_CARD:  RDATA <= {7'h00, smart_card_select};
                OFS_STATUS:      RDATA <= {6'h00, parity_error, transmit_end_flag};
                default:         RDATA <= 8'h00;
            endcase
        end else begin
            RDATA <= 8'h00;
        end
    end

    // clocks per bit decode
    always_comb begin
        unique case (serial_mode_register[BIT_CPB_HI:BIT_CPB_LO])
            2'b00: next_clocks_per_bit = CPB_00; // R8
            2'b01: next_clocks_per_bit = CPB_01; // R8
            2'b10: next_clocks_per_bit = CPB_10; // R8
            2'b11: next_clocks_per_bit = CPB_11; // R8
        endcase
    end

    // field layout depends on smart-card select
    always_comb begin
        next_cfg            = '0;
        next_cfg.smart_card = smart_card_select; // R1
        next_cfg.prescaler  = serial_mode_register[BIT_PRESC_HI:BIT_PRESC_LO]; // R9
        next_cfg.parity_en  = serial_mode_register[BIT_PARITY_EN]; // R5
        next_cfg.parity_odd = serial_mode_register[BIT_PARITY_ODD]; // R7
        if (smart_card_select) begin
            next_cfg.early_end      = serial_mode_register[BIT_EARLY_END]; // R1
            next_cfg.clock_out_ctrl = serial_mode_register[BIT_EARLY_END]; // R3
            next_cfg.block_mode     = serial_mode_register[BIT_BLOCK_XFER]; // R4
            next_cfg.clocks_per_bit = next_clocks_per_bit; // R1
        end else begin
            next_cfg.sync_mode = serial_mode_register[BIT_SYNC_MODE]; // R10
            next_cfg.char_7bit = serial_mode_register[BIT_CHAR_7BIT];
            next_cfg.two_stop  = serial_mode_register[BIT_TWO_STOP];
            next_cfg.multiproc = serial_mode_register[BIT_MULTIPROC];
            if (serial_mode_register[BIT_SYNC_MODE] ||
                serial_mode_register[BIT_MULTIPROC]) begin
                next_cfg.parity_en = 1'b0;
            end
        end
        if (!next_cfg.parity_en) begin
            next_cfg.parity_odd = 1'b0; // R7
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            MODE_CFG <= '0;
        end else begin
            MODE_CFG <= next_cfg;
        end
    end

    // baud rate generator input
    scm_prescaler u_prescaler (
        .clk     (CLK_SYS),
        .reset   (RESET),
        .restart (TX_START),
        .select  (serial_mode_register[BIT_PRESC_HI:BIT_PRESC_LO]), // R9
        .tick    (presc_tick)
    );

    // bit interval counter: S prescaled clocks per etu
    always_ff @(posedge CLK_SYS) begin
        if (RESET || TX_START) begin
            clock_count <= 9'h000;
            etu_pulse   <= 1'b0;
        end else if (presc_tick) begin
            if (clock_count >= next_clocks_per_bit - 9'h001) begin // R8
                clock_count <= 9'h000;
                etu_pulse   <= 1'b1;
            end else begin
                clock_count <= clock_count + 9'h001;
                etu_pulse   <= 1'b0;
            end
        end else begin
            etu_pulse <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            BAUD_TICK <= 1'b0;
            ETU_TICK  <= 1'b0;
        end else begin
            BAUD_TICK <= presc_tick;
            ETU_TICK  <= etu_pulse;
        end
    end

    // early-end moves transmit end forward
    assign end_etu = (smart_card_select && serial_mode_register[BIT_EARLY_END]) ?
                     NORMAL_END_ETU - EARLY_END_ETU : NORMAL_END_ETU; // R2

    // transmit end timing
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            etu_count         <= 5'h00;
            timing_active     <= 1'b0;
            transmit_end_flag <= RST_TX_END;
        end else if (TX_START) begin
            etu_count         <= 5'h00;
            timing_active     <= 1'b1;
            transmit_end_flag <= 1'b0;
        end else if (timing_active && etu_pulse) begin
            etu_count <= etu_count + 5'h01;
            if (etu_count + 5'h01 >= end_etu) begin // R2
                timing_active     <= 1'b0;
                transmit_end_flag <= 1'b1;
            end
        end
    end

    // parity generation and check
    assign rx_bad = (^RX_CHAR ^ RX_PARITY_BIT) != serial_mode_register[BIT_PARITY_ODD]; // R7
    assign clear_parity = WR && (ADDR == OFS_STATUS) && WDATA[BIT_PARITY_ERR];

    // set beats a simultaneous write-one clear
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            parity_error <= 1'b0;
        end else if (RX_VALID && next_cfg.parity_en && rx_bad) begin // R5
            parity_error <= 1'b1;
        end else if (clear_parity) begin
            parity_error <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            TX_PARITY_BIT <= 1'b0;
            TX_END        <= RST_TX_END;
            PARITY_ERROR  <= 1'b0;
        end else begin
            TX_PARITY_BIT <= next_cfg.parity_en &
                             (^TX_CHAR ^ serial_mode_register[BIT_PARITY_ODD]); // R5
            TX_END        <= transmit_end_flag;
            PARITY_ERROR  <= parity_error;
        end
    end

endmodule

// ==== testbench/smart_card_mode_reg_props.sv ====
`timescale 1ns/1ns
module scm_props
    import scm_pkg::*;
(
    input  wire logic       CLK_SYS,       // clock
    input  wire logic       RESET,         // reset
    input  wire logic [1:0] ADDR,          // address
    input  wire logic [7:0] WDATA,         // write data
    input  wire logic       WR,            // write strobe
    input  wire logic [7:0] TX_CHAR,       // tx char
    input  wire logic       RX_VALID,      // rx strobe
    input  wire logic [7:0] RX_CHAR,       // rx char
    input  wire logic       RX_PARITY_BIT, // rx parity
    input  wire logic       TX_START,      // tx start
    input  wire scm_cfg_t   MODE_CFG,      // decoded mode
    input  wire logic       TX_PARITY_BIT, // tx parity
    input  wire logic       TX_END,        // tx end
    input  wire logic       PARITY_ERROR   // parity error
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    logic clr;
    assign clr = WR && ADDR == OFS_STATUS && WDATA[BIT_PARITY_ERR];
    function automatic logic [8:0] cpb(input logic [1:0] k);
        return k == 2'h0 ? CPB_00 : k == 2'h1 ? CPB_01 : k == 2'h2 ? CPB_10 : CPB_11;
    endfunction
    sequence mode_wr;
        WR && ADDR == OFS_SERIAL_MODE ##2 1'b1;
    endsequence
    sequence quiet;
        $stable(MODE_CFG) [*3];
    endsequence
    layout_gate_a: assert property (!MODE_CFG.smart_card |-> !MODE_CFG.early_end
        && !MODE_CFG.block_mode) else $error("smart fields set in normal mode");
    clock_out_a: assert property (MODE_CFG.smart_card |->
        MODE_CFG.clock_out_ctrl == MODE_CFG.early_end) else $error("clock control off");
    smart_decode_a: assert property (mode_wr ##0 MODE_CFG.smart_card |->
        MODE_CFG.early_end == $past(WDATA[7], 2) && MODE_CFG.block_mode == $past(WDATA[6], 2))
        else $error("mode bits not decoded");
    cpb_decode_a: assert property (mode_wr ##0 MODE_CFG.smart_card |->
        MODE_CFG.clocks_per_bit == cpb($past(WDATA[3:2], 2))) else $error("bad clocks per bit");
    presc_decode_a: assert property (mode_wr ##0 MODE_CFG.smart_card |->
        MODE_CFG.prescaler == $past(WDATA[1:0], 2)) else $error("bad prescaler");
    sync_decode_a: assert property (mode_wr ##0 !MODE_CFG.smart_card |->
        MODE_CFG.sync_mode == $past(WDATA[7], 2)) else $error("bad sync mode");
    tx_parity_a: assert property (quiet ##0 $stable(TX_CHAR) && MODE_CFG.smart_card |->
        TX_PARITY_BIT == (MODE_CFG.parity_en && (^TX_CHAR ^ MODE_CFG.parity_odd)))
        else $error("bad tx parity");
    rx_parity_a: assert property (quiet ##0 RX_VALID && MODE_CFG.smart_card &&
        MODE_CFG.parity_en && (^RX_CHAR ^ RX_PARITY_BIT) != MODE_CFG.parity_odd
        |-> ##2 PARITY_ERROR) else $error("parity error missed");
    err_sticky_a: assert property (PARITY_ERROR && !$past(clr) |=> PARITY_ERROR)
        else $error("parity error dropped");
    tx_end_drop_a: assert property (TX_START |-> ##2 !TX_END) else $error("tx end held");
endmodule

bind scm_top scm_props u_props (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .TX_CHAR(TX_CHAR), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
    .RX_PARITY_BIT(RX_PARITY_BIT), .TX_START(TX_START), .MODE_CFG(MODE_CFG),
    .TX_PARITY_BIT(TX_PARITY_BIT), .TX_END(TX_END), .PARITY_ERROR(PARITY_ERROR));

// ==== testbench/tb.sv ====
`timescale 1ns/1ns
module tb;
    import scm_pkg::*;
    localparam logic [4:0] END_ETU = 5'h0C;
    logic       CLK_SYS = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, TX_START = 1'b0;
    logic       RX_VALID = 1'b0, RX_PARITY_BIT = 1'b0;
    logic [1:0] ADDR = 2'h0;
    logic [7:0] WDATA = 8'h00, TX_CHAR = 8'h00, RX_CHAR = 8'h00, RDATA, d, c;
    logic       TX_PARITY_BIT, BAUD_TICK, ETU_TICK, TX_END, PARITY_ERROR;
    scm_cfg_t   MODE_CFG;
    int         errors = 0;
    int         checked = 0;

    always #2 CLK_SYS = ~CLK_SYS;

    scm_top #(.NORMAL_END_ETU(END_ETU)) uut (.CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TX_START(TX_START),
        .TX_CHAR(TX_CHAR), .RX_VALID(RX_VALID), .RX_CHAR(RX_CHAR),
        .RX_PARITY_BIT(RX_PARITY_BIT), .MODE_CFG(MODE_CFG), .TX_PARITY_BIT(TX_PARITY_BIT),
        .BAUD_TICK(BAUD_TICK), .ETU_TICK(ETU_TICK), .TX_END(TX_END),
        .PARITY_ERROR(PARITY_ERROR));

    function automatic int s_of(input logic [1:0] k);
        return k == 2'h0 ? 32 : k == 2'h1 ? 64 : k == 2'h2 ? 372 : 256;
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] v);
        @(posedge CLK_SYS);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= v;
        @(posedge CLK_SYS);
        WR <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [7:0] exp);
        @(posedge CLK_SYS);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge CLK_SYS);
        RD <= 1'b0;
        #1 chk(RDATA, exp);
    endtask

    task automatic run_tx(input int etus, input int s, input int dv);
        int n;
        int b;
        int last;
        n = 0;
        b = 0;
        last = 0;
        @(posedge CLK_SYS);
        TX_START <= 1'b1;
        @(posedge CLK_SYS);
        TX_START <= 1'b0;
        @(posedge CLK_SYS);
        #1 chk(TX_END, 1'b0);
        for (int t = 0; t < 6000 && !TX_END; t++) begin
            @(posedge CLK_SYS);
            #1 b += BAUD_TICK;
            if (ETU_TICK) begin
                if (n > 0) chk(t - last, s * dv);
                if (n > 0) chk(b, s);
                n++;
                last = t;
                b = 0;
            end
        end
        chk(n, etus);
    endtask

    task automatic report_and_stop();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        report_and_stop();
    end

    initial begin
        void'($urandom(3943));
        repeat (8) @(posedge CLK_SYS);
        RESET <= 1'b0;
        rd(OFS_SERIAL_MODE, 8'h00);
        wr(OFS_STATUS, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3, 8'h00);
        rd(OFS_STATUS, 8'h01);
        wr(OFS_SERIAL_MODE, 8'h80);
        repeat (2) @(posedge CLK_SYS);
        #1 chk({MODE_CFG.sync_mode, MODE_CFG.early_end}, 2'b10);
        wr(OFS_SERIAL_MODE, 8'h10);
        TX_CHAR <= 8'h03;
        repeat (2) @(posedge CLK_SYS);
        #1 chk({MODE_CFG.parity_en, MODE_CFG.parity_odd, TX_PARITY_BIT}, 3'b000);
        wr(OFS_SERIAL_MODE, 8'h30);
        repeat (2) @(posedge CLK_SYS);
        #1 chk({MODE_CFG.parity_en, MODE_CFG.parity_odd, TX_PARITY_BIT}, 3'b111);
        wr(OFS_SMART_CARD, 8'h01);
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom);
            d[5] = 1'b1;
            d[3:0] = {i[1:0], i[2:1]};
            wr(OFS_SERIAL_MODE, d);
            rd(OFS_SERIAL_MODE, d);
            repeat (2) @(posedge CLK_SYS);
            #1 chk({MODE_CFG.early_end, MODE_CFG.block_mode}, d[7:6]);
            chk(MODE_CFG.clock_out_ctrl, d[7]);
            chk(MODE_CFG.clocks_per_bit, s_of(d[3:2]));
            chk(MODE_CFG.prescaler, d[1:0]);
            c = 8'($urandom);
            @(posedge CLK_SYS);
            TX_CHAR <= c;
            @(posedge CLK_SYS);
            RX_CHAR <= c;
            RX_PARITY_BIT <= ^c ^ d[4] ^ i[0];
            RX_VALID <= 1'b1;
            @(posedge CLK_SYS);
            RX_VALID <= 1'b0;
            repeat (3) @(posedge CLK_SYS);
            #1 chk(TX_PARITY_BIT, ^c ^ d[4]);
            chk(PARITY_ERROR, i[0]);
            wr(OFS_STATUS, 8'h02);
            repeat (2) @(posedge CLK_SYS);
            #1 chk(PARITY_ERROR, 1'b0);
        end
        for (int k = 0; k < 2; k++) begin
            wr(OFS_SERIAL_MODE, {~k[0], 3'b010, 1'b0, k[0], 1'b0, k[0]});
            run_tx(k ? END_ETU : END_ETU - 11, s_of({1'b0, k[0]}), 1 << (2 * k));
        end
        report_and_stop();
    end
endmodule
